/* verilog/pcg_pkg.sv */
// press cycle guard: shared constants, encodings and carrier types
package pcg_pkg;

    // ========================================================
    // timing
    localparam int unsigned PCG_CLK_HZ       = 50_000_000;
    localparam int unsigned PCG_CYC_PER_MS   = PCG_CLK_HZ / 1000;
    localparam int unsigned PCG_PULSE_SHORT_MS = 100;
    localparam int unsigned PCG_PULSE_LONG_MS  = 350;
    localparam int unsigned PCG_ACK_MAX_MS   = 30_000;
    localparam int unsigned PCG_BYPASS_MS    = 500;
    localparam int unsigned PCG_CYCLE_MON_MS = 5_000;
    // cycle counts: exact multiples, so no rounding is lost
    localparam int unsigned PCG_SHORT_CNT    = PCG_PULSE_SHORT_MS * PCG_CYC_PER_MS;
    localparam int unsigned PCG_LONG_CNT     = PCG_PULSE_LONG_MS * PCG_CYC_PER_MS;
    localparam int unsigned PCG_ACK_MAX_CNT  = PCG_ACK_MAX_MS * PCG_CYC_PER_MS;
    localparam int unsigned PCG_BYPASS_CNT   = PCG_BYPASS_MS * PCG_CYC_PER_MS;
    localparam int unsigned PCG_CYCLE_CNT    = PCG_CYCLE_MON_MS * PCG_CYC_PER_MS;

    // ========================================================
    // setting encodings
    localparam logic [1:0] PCG_RLK_NONE   = 2'h1;
    localparam logic [1:0] PCG_RLK_ALWAYS = 2'h2;
    localparam logic [1:0] PCG_RLK_DOWN   = 2'h3;
    localparam logic [1:0] PCG_POS_TDC    = 2'h2;
    localparam logic [1:0] PCG_S2_REQ     = 2'h3;
    localparam int         PCG_PIN_W      = 6;
    localparam logic [5:0] PCG_PIN_RST    = 6'h00;

    // ========================================================
    // carriers
    typedef struct packed {
        logic [1:0] relaunch_lock;
        logic [1:0] start_pos;
        logic [1:0] start2_mode;
        logic       ack_long;
        logic       intv_long;
        logic       bypass_en;
        logic       cyc_mon_en;
        logic       fault_en;
    } pcg_cfg_t;

    typedef struct packed {
        logic static_ok;
        logic start_ok;
        logic guard_clear;
        logic tdc;
        logic upstroke;
        logic ack;
    } pcg_pins_t;

    typedef struct packed {
        logic permit;
        logic reset_needed;
        logic intv_needed;
        logic seq_timeout;
        logic unauth_entry;
        logic off_pos_block;
        logic fault;
    } pcg_stat_t;

    typedef enum logic [2:0] {
        ST_ACK  = 3'h1,
        ST_INTV = 3'h2,
        ST_RUN  = 3'h4
    } pcg_state_t;

endpackage : pcg_pkg

/* verilog/pcg_pulse_chk.sv */
// press cycle guard: pulse width checker for one active-high level
`timescale 1ns/100ps
`default_nettype none

module pcg_pulse_chk
    import pcg_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        level,
    input  wire logic [31:0] min_cnt,
    input  wire logic [31:0] max_cnt,
    input  wire logic        max_en,
    output logic             ok
);

    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic        level_reg;
    logic        ok_reg;
    logic        ok_next;

    // ========================================================
    // width measurement, saturating so a stuck level never wraps
    always_comb
    begin
        cnt_next = cnt_reg;
        ok_next  = 1'b0;
        if (level)
        begin
            if (cnt_reg != 32'hFFFFFFFF)
                cnt_next = cnt_reg + 32'h1;
        end
        else
        begin
            cnt_next = 32'h0;
            if (level_reg && cnt_reg >= min_cnt && (!max_en || cnt_reg <= max_cnt))
                ok_next = 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            cnt_reg   <= 32'h0;
            level_reg <= 1'b0;
            ok_reg    <= 1'b0;
        end
        else
        begin
            cnt_reg   <= cnt_next;
            level_reg <= level;
            ok_reg    <= ok_next;
        end
    end

    assign ok = ok_reg;

    // ========================================================
    // checks
    width_min_a: assert property (@(posedge mclk) disable iff (sys_rst)
        ok_reg |-> $past(cnt_reg) >= $past(min_cnt))
        else $error("pulse accepted below minimum width");

    width_max_a: assert property (@(posedge mclk) disable iff (sys_rst)
        ok_reg && $past(max_en) |-> $past(cnt_reg) <= $past(max_cnt))
        else $error("pulse accepted above maximum width");

endmodule : pcg_pulse_chk

`default_nettype wire

/* verilog/pcg_guard.sv */
// press cycle guard: drive permit sequencer for cyclic press operation
// How it works
// - acknowledge valid only after minimum high time
// - intervention valid only after minimum low time
// - start position two: relaunch only at TDC
// - stop by permit/guard blocks until TDC
// - static permit low drops permit at once
// - start permit gates only the first rise
// - intervention is high-low-high on guard input
// - TDC marks end of each press cycle
// - upstroke bypass masks guard before TDC, timed
// - lock always: bypass intervention after TDC locks
// - lock encoding: none, always, downstroke/initial
// - acknowledge clears reset-needed, max thirty seconds
// - permit and reset-needed never both high
// - reset-needed high while acknowledge expected
// - timeout flag when cycle monitoring limit passed
// - fault shows timeout or unauthorized entry
// - permit derived from settings and inputs
// - intervention-needed high while one is expected
// - unauthorized-entry on intervention not permitted
`timescale 1ns/100ps
`default_nettype none

module pcg_guard
    import pcg_pkg::*;
#(
    parameter int unsigned SHORT_CNT   = PCG_SHORT_CNT,
    parameter int unsigned LONG_CNT    = PCG_LONG_CNT,
    parameter int unsigned ACK_MAX_CNT = PCG_ACK_MAX_CNT,
    parameter int unsigned BYPASS_CNT  = PCG_BYPASS_CNT,
    parameter int unsigned CYCLE_CNT   = PCG_CYCLE_CNT
)
(
    input  wire logic      mclk,
    input  wire logic      sys_rst,
    input  wire pcg_cfg_t  cfg,
    input  wire pcg_pins_t pins,
    input  wire logic      drive_active,
    input  wire logic      other_mode_start,
    output pcg_stat_t      stat
);

    // ========================================================
    // pin synchronisers
    logic [PCG_PIN_W-1:0] meta_reg;
    logic [PCG_PIN_W-1:0] sync_reg;
    pcg_pins_t            pin_s;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            meta_reg <= PCG_PIN_RST;
            sync_reg <= PCG_PIN_RST;
        end
        else
        begin
            meta_reg <= pins;
            sync_reg <= meta_reg;
        end
    end

    assign pin_s = pcg_pins_t'(sync_reg);

    // ========================================================
    // state
    pcg_state_t  state_reg;
    pcg_state_t  state_next;
    logic        unauth_reg;
    logic        unauth_next;
    logic        tmo_reg;
    logic        tmo_next;
    logic        offpos_reg;
    logic        offpos_next;
    logic        byp_seen_reg;
    logic        byp_seen_next;
    logic        tdc_d_reg;
    logic        guard_d_reg;
    logic        drive_d_reg;
    logic [31:0] byp_cnt_reg;
    logic [31:0] byp_cnt_next;
    logic [31:0] cyc_cnt_reg;
    logic [31:0] cyc_cnt_next;

    logic        tdc_rise;
    logic        byp_on;
    logic        guard_low;
    logic        intv_start;
    logic        intv_ok;
    logic        ack_ok;
    logic        lock_needed;
    logic        stop_lock;
    logic        pos_ok;
    logic        start_allowed;
    pcg_state_t  restart_state;

    // ========================================================
    // pulse checkers
    pcg_pulse_chk u_ack_chk (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .level   (pin_s.ack),
        .min_cnt (cfg.ack_long ? 32'(LONG_CNT) : 32'(SHORT_CNT)),
        .max_cnt (32'(ACK_MAX_CNT)),
        .max_en  (1'b1),
        .ok      (ack_ok)
    );

    pcg_pulse_chk u_intv_chk (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .level   (guard_low),
        .min_cnt (cfg.intv_long ? 32'(LONG_CNT) : 32'(SHORT_CNT)),
        .max_cnt (32'h0),
        .max_en  (1'b0),
        .ok      (intv_ok)
    );

    // ========================================================
    // derived conditions
    always_comb
    begin
        tdc_rise   = pin_s.tdc && !tdc_d_reg;
        // bypass window closes at TDC or when its timer runs out
        byp_on     = cfg.bypass_en && pin_s.upstroke && !pin_s.tdc
                     && (byp_cnt_reg < BYPASS_CNT);
        guard_low  = !pin_s.guard_clear && !byp_on;
        intv_start = guard_low && !guard_d_reg;
        lock_needed = cfg.relaunch_lock != PCG_RLK_NONE;
        // downstroke or initial position: not on the upstroke, or at TDC
        stop_lock  = (cfg.relaunch_lock == PCG_RLK_ALWAYS)
                     || (cfg.relaunch_lock == PCG_RLK_DOWN
                         && (!pin_s.upstroke || pin_s.tdc));
        restart_state = stop_lock ? ST_ACK : ST_INTV;
        pos_ok     = (cfg.start_pos != PCG_POS_TDC) || pin_s.tdc;
        start_allowed = pos_ok && !offpos_reg && pin_s.static_ok
                        && (cfg.start2_mode != PCG_S2_REQ || pin_s.start_ok);
    end

    // ========================================================
    // sequencer next state
    always_comb
    begin
        state_next    = state_reg;
        unauth_next   = unauth_reg;
        tmo_next      = tmo_reg;
        offpos_next   = offpos_reg;
        byp_seen_next = byp_seen_reg;
        cyc_cnt_next  = 32'h0;

        if (cfg.bypass_en && pin_s.upstroke && !pin_s.tdc)
            byp_cnt_next = (byp_cnt_reg == 32'hFFFFFFFF) ? byp_cnt_reg
                                                         : byp_cnt_reg + 32'h1;
        else
            byp_cnt_next = 32'h0;

        // clear first so that a new stop in the same cycle wins
        if (pin_s.tdc && !other_mode_start)
            offpos_next = 1'b0;
        if (state_reg == ST_RUN && (!pin_s.static_ok || guard_low))
            offpos_next = 1'b1;
        // a drive that stops away from TDC leaves the press mid-stroke
        if (cfg.start_pos == PCG_POS_TDC && drive_d_reg && !drive_active
            && !pin_s.tdc)
            offpos_next = 1'b1;

        case (state_reg)
            ST_ACK:
            begin
                if (!lock_needed || ack_ok)
                    state_next = ST_INTV;
            end
            ST_INTV:
            begin
                if (cfg.cyc_mon_en)
                    cyc_cnt_next = cyc_cnt_reg + 32'h1;
                if (cfg.cyc_mon_en && cyc_cnt_reg >= CYCLE_CNT)
                begin
                    tmo_next     = 1'b1;
                    cyc_cnt_next = 32'h0;
                    state_next   = lock_needed ? ST_ACK : ST_INTV;
                end
                else if (intv_ok && start_allowed)
                begin
                    state_next  = ST_RUN;
                    tmo_next    = 1'b0;
                    unauth_next = 1'b0;
                end
            end
            ST_RUN:
            begin
                if (!pin_s.guard_clear && byp_on)
                    byp_seen_next = 1'b1;
                if (intv_start)
                begin
                    unauth_next = 1'b1;
                    state_next  = restart_state;
                end
                else if (!pin_s.static_ok)
                    state_next = lock_needed ? ST_ACK : ST_INTV;
                else if (tdc_rise)
                begin
                    byp_seen_next = 1'b0;
                    if (byp_seen_reg && cfg.relaunch_lock == PCG_RLK_ALWAYS)
                    begin
                        unauth_next = 1'b1;
                        state_next  = ST_ACK;
                    end
                    else
                        state_next = ST_INTV;
                end
            end
            default:
            begin
                state_next = ST_ACK;
            end
        endcase

        if (state_next != ST_RUN)
            byp_seen_next = 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            state_reg    <= ST_ACK;
            unauth_reg   <= 1'b0;
            tmo_reg      <= 1'b0;
            offpos_reg   <= 1'b0;
            byp_seen_reg <= 1'b0;
            tdc_d_reg    <= 1'b0;
            guard_d_reg  <= 1'b0;
            drive_d_reg  <= 1'b0;
            byp_cnt_reg  <= 32'h0;
            cyc_cnt_reg  <= 32'h0;
        end
        else
        begin
            state_reg    <= state_next;
            unauth_reg   <= unauth_next;
            tmo_reg      <= tmo_next;
            offpos_reg   <= offpos_next;
            byp_seen_reg <= byp_seen_next;
            tdc_d_reg    <= pin_s.tdc;
            guard_d_reg  <= guard_low;
            drive_d_reg  <= drive_active;
            byp_cnt_reg  <= byp_cnt_next;
            cyc_cnt_reg  <= cyc_cnt_next;
        end
    end

    // ========================================================
    // outputs
    always_comb
    begin
        // static permit gates combinationally so the drop costs no cycle
        stat.permit        = state_reg == ST_RUN && pin_s.static_ok;
        stat.reset_needed  = state_reg == ST_ACK;
        stat.intv_needed   = state_reg == ST_INTV;
        stat.seq_timeout   = tmo_reg;
        stat.unauth_entry  = unauth_reg;
        stat.off_pos_block = offpos_reg;
        stat.fault         = cfg.fault_en && (tmo_reg || unauth_reg);
    end

    // ========================================================
    // checks
    default clocking pcg_cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    sequence intv_done_s;
        state_reg == ST_INTV && intv_ok && start_allowed
        && !(cfg.cyc_mon_en && cyc_cnt_reg >= CYCLE_CNT);
    endsequence

    sequence run_entered_s;
        state_reg == ST_RUN ##1 1'b1;
    endsequence

    sequence lock_cause_s;
        state_reg == ST_RUN && tdc_rise && byp_seen_reg && !intv_start
        && pin_s.static_ok && cfg.relaunch_lock == PCG_RLK_ALWAYS;
    endsequence

    out_excl_a: assert property (!(stat.permit && stat.reset_needed))
        else $error("permit and reset-needed high together");

    static_drop_a: assert property (!pin_s.static_ok |-> !stat.permit)
        else $error("permit high with static permit low");

    ack_clear_a: assert property ($fell(stat.reset_needed) |->
        $past(ack_ok) || $past(cfg.relaunch_lock) == PCG_RLK_NONE)
        else $error("reset-needed cleared without valid acknowledge");

    tdc_start_a: assert property ($rose(stat.permit)
        && cfg.start_pos == PCG_POS_TDC |-> $past(pin_s.tdc))
        else $error("relaunch away from top dead centre");

    start2_gate_a: assert property ($rose(stat.permit)
        && cfg.start2_mode == PCG_S2_REQ |-> $past(pin_s.start_ok))
        else $error("permit rose with start permit low");

    intv_run_a: assert property (intv_done_s |=> run_entered_s)
        else $error("valid intervention did not start the run");

    unauth_flag_a: assert property (state_reg == ST_RUN && intv_start
        |=> stat.unauth_entry && state_reg != ST_RUN)
        else $error("intervention in run not flagged");

    bypass_lock_a: assert property (lock_cause_s
        |=> stat.reset_needed && stat.unauth_entry && !stat.permit)
        else $error("bypass intervention did not lock");

    cycle_tmo_a: assert property (state_reg == ST_INTV && cfg.cyc_mon_en
        && cyc_cnt_reg >= CYCLE_CNT |=> stat.seq_timeout)
        else $error("cycle limit passed without timeout");

    offpos_set_a: assert property (state_reg == ST_RUN
        && !pin_s.static_ok |=> stat.off_pos_block ##1 stat.intv_needed
        || stat.reset_needed || stat.intv_needed)
        else $error("stop in run did not block relaunch");

    // a masked guard must not end the run: neither as entry nor as stop
    bypass_mask_a: assert property (state_reg == ST_RUN && byp_on
        && pin_s.static_ok |=> state_reg == ST_RUN)
        else $error("guard seen during bypass window");

    fault_out_a: assert property (tmo_reg && cfg.fault_en
        |-> stat.fault)
        else $error("fault output missing on timeout");

endmodule : pcg_guard

`default_nettype wire

/* tb/pcg_press_model.sv */
// press cycle guard bench: light curtain, press contact monitor and drive model
`timescale 1ns/100ps
`default_nettype none

module pcg_press_model
    import pcg_pkg::*;
#(
    parameter int STROKE = 80
)
(
    input  wire logic  mclk,
    input  wire logic  sys_rst,
    input  wire logic  permit,
    input  wire logic  static_cmd,
    input  wire logic  start_cmd,
    input  wire logic  guard_cmd,
    input  wire logic  ack_cmd,
    input  wire logic  home_cmd,
    output pcg_pins_t  pins,
    output logic       drive_active,
    output logic [7:0] pos
);

    // ========================================================
    // crank position
    // the crank turns only while released; a stop keeps its angle
    always @(negedge mclk)
    begin
        if (sys_rst || home_cmd)
            pos <= 8'h00;
        else if (permit)
            pos <= (pos == 8'(STROKE - 1)) ? 8'h00 : pos + 8'h01;
    end

    // ========================================================
    // pins
    // dead-centre zone is wide so a stop after the cycle end stays inside it
    always_comb
    begin
        pins.static_ok   = static_cmd;
        pins.start_ok    = start_cmd;
        pins.guard_clear = guard_cmd;
        pins.tdc         = (pos < 8'h08);
        pins.upstroke    = (pos >= 8'(STROKE / 2));
        pins.ack         = ack_cmd;
    end

    assign drive_active = permit;

endmodule : pcg_press_model

`default_nettype wire

/* tb/press_cycle_guard_tb.sv */
// press cycle guard bench: directed sequences against the documented behaviour
`timescale 1ns/100ps
`default_nettype none

module press_cycle_guard_tb;
    import pcg_pkg::*;

    localparam int SHORT  = 10;
    localparam int LONG   = 35;
    localparam int ACKMAX = 300;
    localparam int CYC    = 500;
    localparam int STROKE = 80;
    localparam int B_PERMIT = 6;
    localparam int B_RSTN   = 5;
    localparam int B_INTV   = 4;
    localparam int B_TMO    = 3;
    localparam int B_UNAUTH = 2;
    localparam int B_OFFPOS = 1;
    localparam int B_FAULT  = 0;

    logic       mclk;
    logic       sys_rst;
    pcg_cfg_t   cfg;
    pcg_pins_t  pins;
    pcg_stat_t  stat;
    logic [6:0] sb;
    logic       drive_active;
    logic       other_mode_start;
    logic       static_cmd;
    logic       start_cmd;
    logic       guard_cmd;
    logic       ack_cmd;
    logic       home_cmd;
    logic [7:0] pos;
    int         fail_count;
    int         tests_run;

    assign sb = stat;

    initial mclk = 1'h0;
    always #10 mclk = ~mclk;

    pcg_guard #(
        .SHORT_CNT   (SHORT),
        .LONG_CNT    (LONG),
        .ACK_MAX_CNT (ACKMAX),
        .BYPASS_CNT  (50),
        .CYCLE_CNT   (CYC)
    ) dut (
        .mclk             (mclk),
        .sys_rst          (sys_rst),
        .cfg              (cfg),
        .pins             (pins),
        .drive_active     (drive_active),
        .other_mode_start (other_mode_start),
        .stat             (stat)
    );

    pcg_press_model #(.STROKE(STROKE)) partner (
        .mclk         (mclk),
        .sys_rst      (sys_rst),
        .permit       (stat.permit),
        .static_cmd   (static_cmd),
        .start_cmd    (start_cmd),
        .guard_cmd    (guard_cmd),
        .ack_cmd      (ack_cmd),
        .home_cmd     (home_cmd),
        .pins         (pins),
        .drive_active (drive_active),
        .pos          (pos)
    );

    // ========================================================
    // helpers
    task automatic final_report();
        if (fail_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick

    task automatic chk(input int b, input logic exp);
        tests_run++;
        if (sb[b] !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, sb[b], exp);
        end
    endtask : chk

    task automatic do_reset(input pcg_cfg_t c);
        sys_rst    = 1'h1;
        cfg        = c;
        static_cmd = 1'h1;
        start_cmd  = 1'h1;
        guard_cmd  = 1'h1;
        ack_cmd    = 1'h0;
        home_cmd   = 1'h0;
        tick(20);
        sys_rst = 1'h0;
        tick(4);
    endtask : do_reset

    // operator acknowledge, high for w cycles
    task automatic pulse_ack(input int w);
        ack_cmd = 1'h1;
        tick(w);
        ack_cmd = 1'h0;
        tick(8);
    endtask : pulse_ack

    // guard field entered for w cycles
    task automatic intervene(input int w);
        guard_cmd = 1'h0;
        tick(w);
        guard_cmd = 1'h1;
        tick(8);
    endtask : intervene

    // a hang here surfaces as the compare after it failing
    task automatic wait_bit(input int b, input int lim);
        for (int i = 0; i < lim && sb[b] !== 1'h1; i++)
            tick(1);
    endtask : wait_bit

    task automatic wait_pos(input logic [7:0] p);
        for (int i = 0; i < 4 * STROKE && pos !== p; i++)
            tick(1);
    endtask : wait_pos

    // ========================================================
    // watchdog
    initial
    begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        final_report();
    end

    // ========================================================
    // sequences
    initial
    begin
        fail_count       = 0;
        tests_run        = 0;
        other_mode_start = 1'h0;
        // lock always, long intervention, bypass on
        do_reset('{PCG_RLK_ALWAYS, 2'h0, 2'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1});
        chk(B_RSTN, 1'h1);
        chk(B_PERMIT, 1'h0);
        pulse_ack(SHORT - 2);
        chk(B_RSTN, 1'h1);
        pulse_ack(ACKMAX + 10);
        chk(B_RSTN, 1'h1);
        pulse_ack(SHORT + 3);
        chk(B_RSTN, 1'h0);
        chk(B_INTV, 1'h1);
        intervene(SHORT + 3);
        chk(B_PERMIT, 1'h0);
        chk(B_INTV, 1'h1);
        intervene(LONG + 3);
        chk(B_PERMIT, 1'h1);
        chk(B_RSTN, 1'h0);
        wait_bit(B_INTV, 2 * STROKE);
        chk(B_PERMIT, 1'h0);
        intervene(LONG + 3);
        chk(B_PERMIT, 1'h1);
        wait_pos(8'(STROKE / 2 + 4));
        intervene(12);
        chk(B_UNAUTH, 1'h0);
        chk(B_PERMIT, 1'h1);
        wait_bit(B_RSTN, 2 * STROKE);
        chk(B_UNAUTH, 1'h1);
        chk(B_PERMIT, 1'h0);
        chk(B_FAULT, 1'h1);
        pulse_ack(SHORT + 3);
        intervene(LONG + 3);
        chk(B_UNAUTH, 1'h0);
        wait_pos(8'h14);
        static_cmd = 1'h0;
        tick(3);
        chk(B_PERMIT, 1'h0);
        tick(2);
        chk(B_OFFPOS, 1'h1);
        chk(B_RSTN, 1'h1);
        static_cmd = 1'h1;
        // lock after downstroke stop, relaunch only at dead centre
        do_reset('{PCG_RLK_DOWN, PCG_POS_TDC, 2'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1});
        pulse_ack(SHORT + 3);
        chk(B_RSTN, 1'h1);
        pulse_ack(LONG + 3);
        intervene(SHORT + 3);
        chk(B_PERMIT, 1'h1);
        wait_pos(8'h14);
        guard_cmd = 1'h0;
        tick(4);
        chk(B_UNAUTH, 1'h1);
        chk(B_FAULT, 1'h1);
        chk(B_PERMIT, 1'h0);
        chk(B_OFFPOS, 1'h1);
        chk(B_RSTN, 1'h1);
        guard_cmd = 1'h1;
        tick(4);
        pulse_ack(LONG + 3);
        intervene(SHORT + 3);
        chk(B_PERMIT, 1'h0);
        chk(B_INTV, 1'h1);
        home_cmd         = 1'h1;
        other_mode_start = 1'h1;
        tick(1);
        home_cmd = 1'h0;
        tick(6);
        chk(B_OFFPOS, 1'h1);
        other_mode_start = 1'h0;
        tick(4);
        chk(B_OFFPOS, 1'h0);
        intervene(SHORT + 3);
        chk(B_PERMIT, 1'h1);
        chk(B_UNAUTH, 1'h0);
        // no lock, start permit for first rise, cycle monitor on
        do_reset('{PCG_RLK_NONE, 2'h0, PCG_S2_REQ, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1});
        chk(B_RSTN, 1'h0);
        chk(B_INTV, 1'h1);
        start_cmd = 1'h0;
        intervene(SHORT + 3);
        chk(B_PERMIT, 1'h0);
        tick(CYC + 10);
        chk(B_TMO, 1'h1);
        chk(B_FAULT, 1'h1);
        start_cmd = 1'h1;
        intervene(SHORT + 3);
        chk(B_PERMIT, 1'h1);
        chk(B_TMO, 1'h0);
        start_cmd = 1'h0;
        tick(4);
        chk(B_PERMIT, 1'h1);
        final_report();
    end

endmodule : press_cycle_guard_tb

`default_nettype wire
